// ---- bench/bbcr_host_model.sv ----
/*
  Host model for the byte register port: one write, one read, or a write then a read per call.
  Assumes the device takes a strobe on a rising edge and answers one cycle later.
*/
`timescale 1ns/1ns
module bbcr_host_model
  import bbcr_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic [7:0] i_reg_rdata,
  output logic [7:0] o_reg_addr,
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [7:0] o_reg_wdata
);
  initial begin
    o_reg_addr = 8'h00;
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_wdata = 8'h00;
  end

  // Released lines flip so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    o_reg_addr <= a;
    o_reg_wdata <= (a == BBCR_CH1_CFG_OFS) ? {4'h0, d[3:0]} : d;
    o_reg_wr <= 1'b1;
    @(posedge i_core_clk);
    o_reg_wr <= 1'b0;
    o_reg_addr <= ~a;
    o_reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_core_clk);
    o_reg_addr <= a;
    o_reg_rd <= 1'b1;
    @(posedge i_core_clk);
    o_reg_rd <= 1'b0;
    o_reg_addr <= ~a;
    // Read data stands from the edge after the strobe until the next read
    @(posedge i_core_clk);
    d = i_reg_rdata;
  endtask

  // Write, then read back on the very next edge
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge i_core_clk);
    o_reg_addr <= a;
    o_reg_wdata <= (a == BBCR_CH1_CFG_OFS) ? {4'h0, d[3:0]} : d;
    o_reg_wr <= 1'b1;
    @(posedge i_core_clk);
    o_reg_wr <= 1'b0;
    o_reg_rd <= 1'b1;
    @(posedge i_core_clk);
    o_reg_rd <= 1'b0;
    o_reg_addr <= ~a;
    o_reg_wdata <= ~d;
    @(posedge i_core_clk);
    q = i_reg_rdata;
  endtask
endmodule

// ---- bench/tb_bbcr_top.sv ----
/*
  Self-checking bench for the channel configuration registers.
  Assumes the host model owns the register port; the bench drives the remaining inputs.
*/
`timescale 1ns/1ns
module tb_bbcr_top;
  import bbcr_pkg::*;
  logic i_core_clk, i_rst_b, sre, vhi, onoff, o_ch1_enable, o_ch1_discharge, o_ch2_code_valid;
  logic [3:0] otp1, slots;
  logic [7:0] otp2, addr, wdata, rdata;
  logic wr, rd;
  logic [9:0] o_ch2_peak_limit_ma;
  logic [12:0] o_ch2_target_mv;
  int errors, n_tests;

  bbcr_host_model bbcr_host_model_inst (.i_core_clk(i_core_clk), .i_reg_rdata(rdata), .o_reg_addr(addr),
    .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_wdata(wdata));
  bbcr_top bbcr_top_inst (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_system_reset_event(sre),
    .i_otp_ch1_cfg(otp1), .i_otp_ch2_cfg(otp2), .i_variant_high(vhi), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_wdata(wdata), .i_seq_slot_up(slots), .i_onoff_on(onoff), .o_reg_rdata(rdata),
    .o_ch1_enable(o_ch1_enable), .o_ch1_discharge(o_ch1_discharge), .o_ch2_peak_limit_ma(o_ch2_peak_limit_ma),
    .o_ch2_target_mv(o_ch2_target_mv), .o_ch2_code_valid(o_ch2_code_valid));

  task automatic chk(input string n, input logic [12:0] e, input logic [12:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask

  task automatic test_done;
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    logic [7:0] d;
    bbcr_host_model_inst.rd(a, d);
    chk("register read", {5'h00, e & m}, {5'h00, d & m});
  endtask

  task automatic t_defaults;
    chk("peak limit", 13'd500, {3'h0, o_ch2_peak_limit_ma});
    chk("target mv", 13'd1150, o_ch2_target_mv);
    chk("discharge", 13'h1, {12'h0, o_ch1_discharge});
    rd_chk(BBCR_CH1_CFG_OFS, 8'h0B, 8'h0F);
    rd_chk(BBCR_CH2_CFG_OFS, 8'hC7, 8'hFF);
  endtask

  // Every enable code, with sequencer slot and on/off controller both ways
  // Bias taken as already in normal mode; its control sits outside this block
  task automatic t_enable;
    logic e, dbit;
    for (int c = 0; c < 8; c++) begin
      for (int o = 0; o < 2; o++) begin
        dbit = c[0] ^ o[0];
        @(posedge i_core_clk);
        onoff <= o[0];
        slots <= o[0] ? 4'hA : 4'h5;
        bbcr_host_model_inst.wr(BBCR_CH1_CFG_OFS, {4'h0, dbit, c[2:0]});
        cyc(3);
        e = (c < 4) ? slots[c] : ((c >= 6) ? onoff : 1'b0);
        chk("ch1 enable", {12'h0, e}, {12'h0, o_ch1_enable});
        chk("ch1 discharge", {12'h0, dbit & ~e}, {12'h0, o_ch1_discharge});
      end
    end
  endtask

  task automatic t_ch2;
    logic [7:0] v[4] = '{8'h00, 8'h79, 8'hBA, 8'hFF};
    logic [3:0] hi = 4'b0110;
    logic [9:0] lim[4] = '{10'd1000, 10'd866, 10'd707, 10'd500};
    logic [12:0] mv;
    logic [7:0] q;
    for (int i = 0; i < 4; i++) begin
      @(posedge i_core_clk);
      vhi <= hi[i];
      bbcr_host_model_inst.wr_rd(BBCR_CH2_CFG_OFS, v[i], q);
      chk("write readback", {5'h00, v[i]}, {5'h00, q});
      cyc(3);
      mv = (hi[i] ? 13'd2400 : 13'd800) + 13'd50 * {7'h0, v[i][5:0]};
      chk("peak limit", {3'h0, lim[v[i][7:6]]}, {3'h0, o_ch2_peak_limit_ma});
      chk("target mv", mv, o_ch2_target_mv);
      chk("code valid", {12'h0, ~(hi[i] & (v[i][5:0] > 6'd57))}, {12'h0, o_ch2_code_valid});
      rd_chk(BBCR_CH2_CFG_OFS, v[i], 8'hFF);
    end
  endtask

  // Unmapped writes leave registers alone; system reset reloads defaults
  task automatic t_reload;
    bbcr_host_model_inst.wr(BBCR_CH2_CFG_OFS, 8'h12);
    bbcr_host_model_inst.wr(BBCR_CH1_CFG_OFS, 8'h07);
    bbcr_host_model_inst.wr(8'h2E, 8'h55);
    rd_chk(BBCR_CH2_CFG_OFS, 8'h12, 8'hFF);
    rd_chk(BBCR_CH1_CFG_OFS, 8'h07, 8'h0F);
    rd_chk(8'h2E, 8'h00, 8'hFF);
    @(posedge i_core_clk);
    sre <= 1'b1;
    @(posedge i_core_clk);
    sre <= 1'b0;
    rd_chk(BBCR_CH1_CFG_OFS, 8'h0B, 8'h0F);
    rd_chk(BBCR_CH2_CFG_OFS, 8'hC7, 8'hFF);
  endtask

  initial begin
    i_core_clk = 1'b0;
    forever #10 i_core_clk = ~i_core_clk;
  end

  initial begin
    repeat (5000) @(posedge i_core_clk);
    errors++;
    test_done();
  end

  initial begin
    i_rst_b = 1'b0;
    sre = 1'b0;
    vhi = 1'b0;
    onoff = 1'b0;
    slots = 4'h0;
    otp1 = 4'hB;
    otp2 = 8'hC7;
    repeat (12) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    cyc(3);
    t_defaults();
    t_enable();
    t_ch2();
    t_reload();
    test_done();
  end
endmodule

// ---- core/bbcr_ch1_ctrl.sv ----
/*
  Channel-1 enable decode and active-discharge control.
  Assumes sequencer slot and on/off controller levels come from logic on the core clock.
*/
`timescale 1ns/1ns
module bbcr_ch1_ctrl
  import bbcr_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic [3:0] i_seq_slot_up,
  input wire logic i_onoff_on,
  bbcr_ch1_if.ctrl ch,
  output logic o_ch1_discharge
);
  logic on_d;
  logic on_q;
  logic dis_q;

  always_comb begin
    case (bbcr_en_sel_t'(ch.enable_sel))
      BBCR_EN_SLOT0, BBCR_EN_SLOT1, BBCR_EN_SLOT2, BBCR_EN_SLOT3: begin
        on_d = i_seq_slot_up[ch.enable_sel[1:0]];
      end
      BBCR_EN_OFF_A, BBCR_EN_OFF_B: begin
        on_d = 1'b0;
      end
      BBCR_EN_ON_A, BBCR_EN_ON_B: begin
        on_d = i_onoff_on;
      end
      default: begin
        on_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      on_q <= 1'b0;
    end else begin
      on_q <= on_d;
    end
  end

  // Resistor only while the channel is not switching, never fighting the converter
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dis_q <= 1'b0;
    end else begin
      dis_q <= ch.discharge_en & ~on_d;
    end
  end

  assign ch.ch_on = on_q;
  assign o_ch1_discharge = dis_q;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);

  a_slot_follow: assert property ((ch.enable_sel[2] == 1'b0) |=>
    (ch.ch_on == $past(i_seq_slot_up[ch.enable_sel[1:0]]))) else $error("channel on does not follow its slot");
  a_forced_off: assert property ((ch.enable_sel[2:1] == 2'b10) |=> !ch.ch_on)
    else $error("channel on while forced off");
  a_forced_on: assert property ((ch.enable_sel[2:1] == 2'b11) |=> (ch.ch_on == $past(i_onoff_on)))
    else $error("forced on does not track on/off controller");
  a_discharge_off: assert property (o_ch1_discharge == ($past(ch.discharge_en) && !ch.ch_on))
    else $error("discharge not applied exactly while channel off");
endmodule

// ---- core/bbcr_ch1_if.sv ----
/*
  Carrier between the register bank and the channel-1 enable controller.
  Assumes both ends run on the core clock.
*/
`timescale 1ns/1ns
interface bbcr_ch1_if;
  logic discharge_en;
  logic [2:0] enable_sel;
  logic ch_on;
  modport regs (output discharge_en, output enable_sel, input ch_on);
  modport ctrl (input discharge_en, input enable_sel, output ch_on);
endinterface

// ---- core/bbcr_pkg.sv ----
/*
  Constants, field layouts and types for the two buck-boost channel configuration registers.
  Assumes a single core clock domain and a byte-wide register port fed by the serial host engine.
*/
package bbcr_pkg;
  // Register addresses on the byte register port
  localparam logic [7:0] BBCR_CH1_CFG_OFS = 8'h2C;
  localparam logic [7:0] BBCR_CH2_CFG_OFS = 8'h2D;

  // Channel-1 register field positions
  localparam int BBCR_CH1_DIS_POS = 3;
  localparam int BBCR_CH1_EN_LSB = 0;
  localparam int BBCR_CH1_EN_W = 3;
  localparam int BBCR_CH1_IMPL_W = 4;

  // Channel-2 register field positions
  localparam int BBCR_CH2_LIM_LSB = 6;
  localparam int BBCR_CH2_LIM_W = 2;
  localparam int BBCR_CH2_TV_LSB = 0;
  localparam int BBCR_CH2_TV_W = 6;

  // Values held under asynchronous reset, before the default load, and the value read at unmapped addresses
  localparam logic [3:0] BBCR_CH1_RST = 4'h0;
  localparam logic [7:0] BBCR_CH2_RST = 8'h00;
  localparam logic [7:0] BBCR_RDATA_RST = 8'h00;
  localparam logic [7:0] BBCR_UNMAPPED_RD = 8'h00;

  // Cycles from reset release to the default load
  localparam int BBCR_LOAD_DELAY_CYC = 1;

  // Channel-1 enable selections
  typedef enum logic [2:0] {
    BBCR_EN_SLOT0 = 3'h0,
    BBCR_EN_SLOT1 = 3'h1,
    BBCR_EN_SLOT2 = 3'h2,
    BBCR_EN_SLOT3 = 3'h3,
    BBCR_EN_OFF_A = 3'h4,
    BBCR_EN_OFF_B = 3'h5,
    BBCR_EN_ON_A = 3'h6,
    BBCR_EN_ON_B = 3'h7
  } bbcr_en_sel_t;

  // Peak current limit in milliamps per code
  localparam logic [9:0] BBCR_LIM_MA_0 = 10'h3E8;
  localparam logic [9:0] BBCR_LIM_MA_1 = 10'h362;
  localparam logic [9:0] BBCR_LIM_MA_2 = 10'h2C3;
  localparam logic [9:0] BBCR_LIM_MA_3 = 10'h1F4;

  // Target voltage transfer, millivolts
  localparam logic [12:0] BBCR_MV_BASE_LO = 13'h0320;
  localparam logic [12:0] BBCR_MV_BASE_HI = 13'h0960;
  localparam logic [12:0] BBCR_MV_STEP = 13'h0032;
  localparam logic [5:0] BBCR_TV_MAX_HI = 6'h39;
endpackage

// ---- core/bbcr_top.sv ----
/*
  Configuration register pair for a multi-output buck-boost converter: channel-1 enable and
  discharge, channel-2 peak limit and target voltage, with decoded outputs for the analog side.
  Assumes a byte register port driven by the serial host engine on the core clock, one-time
  programmed defaults that are stable, and a one-cycle system reset event pulse.
*/
// What this block does
// - Channel-1 bits 7:4 absent, written zero
// - Discharge bit applies resistor while channel off
// - Enable codes 0-3 follow sequencer slots 0-3
// - Enable codes 4, 5 force channel off
// - Codes 6, 7 on while on/off on
// - Peak limit code maps to four currents
// - Low variant: 0.8 V plus 50 mV steps
// - High variant: 2.4 V, above 5.25 V invalid
`timescale 1ns/1ns
module bbcr_top
  import bbcr_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_system_reset_event,
  input wire logic [3:0] i_otp_ch1_cfg,
  input wire logic [7:0] i_otp_ch2_cfg,
  input wire logic i_variant_high,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [3:0] i_seq_slot_up,
  input wire logic i_onoff_on,
  output logic [7:0] o_reg_rdata,
  output logic o_ch1_enable,
  output logic o_ch1_discharge,
  output logic [9:0] o_ch2_peak_limit_ma,
  output logic [12:0] o_ch2_target_mv,
  output logic o_ch2_code_valid
);
  logic [3:0] ch1_cfg_q;
  logic [7:0] ch2_cfg_q;
  logic load_pend_q;
  logic reload;
  logic wr_ch1;
  logic wr_ch2;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  logic [9:0] lim_ma_d;
  logic [9:0] lim_ma_q;
  logic [12:0] mv_q;
  logic valid_q;
  logic [BBCR_CH2_LIM_W-1:0] ch2_limit;
  logic [BBCR_CH2_TV_W-1:0] ch2_tv;

  bbcr_ch1_if ch1 ();

  // Defaults may not be caught under the asynchronous reset, so they load one edge later
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      load_pend_q <= 1'b1;
    end else begin
      load_pend_q <= 1'b0;
    end
  end

  assign reload = load_pend_q | i_system_reset_event;
  assign wr_ch1 = i_reg_wr && (i_reg_addr == BBCR_CH1_CFG_OFS);
  assign wr_ch2 = i_reg_wr && (i_reg_addr == BBCR_CH2_CFG_OFS);

  // Reload beats a write in the same cycle
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ch1_cfg_q <= BBCR_CH1_RST;
    end else if (reload) begin
      ch1_cfg_q <= i_otp_ch1_cfg;
    end else if (wr_ch1) begin
      ch1_cfg_q <= i_reg_wdata[BBCR_CH1_IMPL_W-1:0];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ch2_cfg_q <= BBCR_CH2_RST;
    end else if (reload) begin
      ch2_cfg_q <= i_otp_ch2_cfg;
    end else if (wr_ch2) begin
      ch2_cfg_q <= i_reg_wdata;
    end
  end

  assign ch1.discharge_en = ch1_cfg_q[BBCR_CH1_DIS_POS];
  assign ch1.enable_sel = ch1_cfg_q[BBCR_CH1_EN_LSB +: BBCR_CH1_EN_W];
  assign ch2_limit = ch2_cfg_q[BBCR_CH2_LIM_LSB +: BBCR_CH2_LIM_W];
  assign ch2_tv = ch2_cfg_q[BBCR_CH2_TV_LSB +: BBCR_CH2_TV_W];

  // Absent channel-1 bits read as zero; unmapped addresses read a fixed value
  always_comb begin
    case (i_reg_addr)
      BBCR_CH1_CFG_OFS: begin
        rdata_d = {4'h0, ch1_cfg_q};
      end
      BBCR_CH2_CFG_OFS: begin
        rdata_d = ch2_cfg_q;
      end
      default: begin
        rdata_d = BBCR_UNMAPPED_RD;
      end
    endcase
  end

  // Read data holds until the next read strobe
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_q <= BBCR_RDATA_RST;
    end else if (i_reg_rd) begin
      rdata_q <= rdata_d;
    end
  end

  always_comb begin
    case (ch2_limit)
      2'h0: begin
        lim_ma_d = BBCR_LIM_MA_0;
      end
      2'h1: begin
        lim_ma_d = BBCR_LIM_MA_1;
      end
      2'h2: begin
        lim_ma_d = BBCR_LIM_MA_2;
      end
      default: begin
        lim_ma_d = BBCR_LIM_MA_3;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lim_ma_q <= BBCR_LIM_MA_0;
    end else begin
      lim_ma_q <= lim_ma_d;
    end
  end

  // Linear in both variants; only the base differs
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mv_q <= BBCR_MV_BASE_LO;
    end else if (i_variant_high) begin
      mv_q <= BBCR_MV_BASE_HI + 13'(ch2_tv) * BBCR_MV_STEP;
    end else begin
      mv_q <= BBCR_MV_BASE_LO + 13'(ch2_tv) * BBCR_MV_STEP;
    end
  end

  // Codes past the top step of the high variant are flagged, the value is still passed on
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      valid_q <= 1'b1;
    end else begin
      valid_q <= !i_variant_high || (ch2_tv <= BBCR_TV_MAX_HI);
    end
  end

  bbcr_ch1_ctrl u_ch1_ctrl (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_seq_slot_up(i_seq_slot_up),
    .i_onoff_on(i_onoff_on),
    .ch(ch1.ctrl),
    .o_ch1_discharge(o_ch1_discharge)
  );

  assign o_reg_rdata = rdata_q;
  assign o_ch1_enable = ch1.ch_on;
  assign o_ch2_peak_limit_ma = lim_ma_q;
  assign o_ch2_target_mv = mv_q;
  assign o_ch2_code_valid = valid_q;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_write_ch2;
    wr_ch2 && !reload;
  endsequence

  sequence s_read_ch2;
    i_reg_rd && (i_reg_addr == BBCR_CH2_CFG_OFS) && !i_reg_wr && !reload;
  endsequence

  a_otp_reload: assert property (i_system_reset_event |=>
    (ch1_cfg_q == $past(i_otp_ch1_cfg)) && (ch2_cfg_q == $past(i_otp_ch2_cfg)))
    else $error("defaults not reloaded on system reset");
  a_write_ch1: assert property ((wr_ch1 && !reload) |=> (ch1_cfg_q == $past(i_reg_wdata[3:0])))
    else $error("channel-1 write not stored");
  a_blank_zero: assert property ((i_reg_rd && i_reg_addr == BBCR_CH1_CFG_OFS) |=>
    (o_reg_rdata[7:4] == 4'h0)) else $error("absent channel-1 bits read nonzero");
  a_write_read: assert property ((s_write_ch2 ##1 s_read_ch2) |=>
    (o_reg_rdata == $past(i_reg_wdata, 2))) else $error("channel-2 readback mismatch");
  a_limit_top: assert property ((ch2_limit == 2'h0) |=> (o_ch2_peak_limit_ma == 10'h3E8))
    else $error("limit code 0 not 1000 mA");
  a_limit_low: assert property ((ch2_limit == 2'h3) |=> (o_ch2_peak_limit_ma == 10'h1F4))
    else $error("limit code 3 not 500 mA");
  a_volt_low: assert property (!i_variant_high |=>
    (o_ch2_target_mv == 13'h0320 + 13'($past(ch2_tv)) * 13'h0032)) else $error("low variant voltage wrong");
  a_volt_high: assert property (i_variant_high |=>
    (o_ch2_target_mv == 13'h0960 + 13'($past(ch2_tv)) * 13'h0032)) else $error("high variant voltage wrong");
  a_code_invalid: assert property ((i_variant_high && ch2_tv > 6'h39) |=> !o_ch2_code_valid)
    else $error("invalid high variant code accepted");
endmodule
